// File: gpio_params.svh
// register offsets, field positions and reset values for the four-port gpio block
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH

// ****************************************************************
// register indices (printed offsets are not all multiples of four)
// ****************************************************************
`define IDX_SEVEN_LATCH    12'h007
`define IDX_SEVEN_DIR      12'h02F
`define IDX_EIGHT_LATCH    12'hFB0
`define IDX_EIGHT_DIR      12'hFB2
`define IDX_SEVEN_PULLUP   12'hFBD
`define IDX_NINE_LATCH     12'hFC0
`define IDX_NINE_DIR       12'hFC1
`define IDX_TEN_LATCH      12'hFC2
`define IDX_TEN_DIR        12'hFC3
`define IDX_TEN_PULLUP     12'hFC4
`define IDX_CONV_CTRL      12'hFC5
`define IDX_WAKE_CTRL      12'hFC6
`define IDX_SYS_CTRL       12'hFC7
`define IDX_EIGHT_PIN      12'hFC8
`define IDX_NINE_PIN       12'hFC9
`define IDX_TEN_PIN        12'hFCA

// ****************************************************************
// field positions
// ****************************************************************
`define CONV_ANALOG_OFF_BIT 4
`define CONV_CHAN_LSB      0
`define WAKE_EN_LSB        4
`define SYS_STOP_BIT       7
`define SYS_DRIVE_BIT      4

// ****************************************************************
// reset values
// ****************************************************************
`define RST_BYTE           8'h00
`define RST_CONV           8'h10
`define RST_SYS            8'h10

`endif

// File: gpio_pkg.sv
// types shared by the gpio block
package gpio_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {
        ST_ADDR = 2'b00,
        ST_DATA = 2'b01
    } bus_phase_e;
endpackage

// File: pin_sync.sv
// two-flop synchroniser for a byte of pin levels
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [7:0] pin_in,
    output var  logic [7:0] pin_out
);
    logic [7:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_q  <= 8'h00;
            pin_out <= 8'h00;
        end else begin
            meta_q  <= pin_in;
            pin_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// File: gpio_ports.sv
// four 8-bit gpio ports with analog sharing, pull-ups and key wakeup, on ahb-lite
//
// Contract
// RL1: every port is eight bits, each bit's direction set separately by software
// RL2: reset clears port seven direction and latch, sets analog disable, inputs read zero
// RL3: a forced-zero port seven bit always reads zero regardless of pin or pull-up
// RL4: port seven dir 0 latch 1 is digital input; dir 1 is always output
// RL5: analog enabled, dir 0 latch 0 connects analog input; latch 1 stays digital
// RL6: reading port seven returns zero for bits in analog input mode
// RL7: converted channel comes from four-bit select field, bits 0 to 3
// RL8: upper four port seven pins feed wakeup inputs gated by bits 4 to 7
// RL9: pull-up bit 1 enables pull-up; never applied while bit is output
// RL10: software must not make an analog-input pin an output
// RL11: software should avoid port writes during conversion
// RL12: reset clears port eight direction and latch; direction 1 means output
// RL13: reset clears port nine direction and latch
// RL14: reset clears port ten direction and latch
// RL15: input bits read the pin level, not the latch
// RL16: stop mode with drive gate cleared disables every output driver
`timescale 1ns/1ps
`default_nettype none
`include "gpio_params.svh"
module gpio_ports (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic [31:0] hrdata,
    output var  logic        hreadyout,
    output var  logic        hresp,
    input  wire logic [7:0]  seven_pin_i,
    output var  logic [7:0]  seven_pin_o,
    output var  logic [7:0]  seven_pin_oe_n,
    output var  logic [7:0]  seven_pullup_on,
    output var  logic [7:0]  seven_analog_connect,
    output var  logic [3:0]  analog_channel_select,
    output var  logic [3:0]  key_wakeup_level,
    input  wire logic [7:0]  eight_pin_i,
    output var  logic [7:0]  eight_pin_o,
    output var  logic [7:0]  eight_pin_oe_n,
    input  wire logic [7:0]  nine_pin_i,
    output var  logic [7:0]  nine_pin_o,
    output var  logic [7:0]  nine_pin_oe_n,
    input  wire logic [7:0]  ten_pin_i,
    output var  logic [7:0]  ten_pin_o,
    output var  logic [7:0]  ten_pin_oe_n,
    output var  logic [7:0]  ten_pullup_on
);

    // ****************************************************************
    // decode helper
    // ****************************************************************
    // maps a register index onto its word-aligned byte address
    function automatic logic hit(input logic [31:0] a, input logic [11:0] idx);
        hit = (a[13:2] == idx) && (a[31:14] == 18'h00000) && (a[1:0] == 2'b00);
    endfunction

    // ****************************************************************
    // register state
    // ****************************************************************
    gpio_pkg::byte_t latch_q [4];       // output latches, ports seven to ten
    gpio_pkg::byte_t dir_q   [4];       // direction, 1 = output
    gpio_pkg::byte_t seven_pu_q;
    gpio_pkg::byte_t ten_pu_q;
    gpio_pkg::byte_t conv_q;
    gpio_pkg::byte_t wake_q;
    gpio_pkg::byte_t sys_q;
    logic            wr_pend_q;
    logic [31:0]     addr_q;
    gpio_pkg::bus_phase_e phase_q;

    // ****************************************************************
    // synchronised pin levels
    // ****************************************************************
    logic [7:0] pin_s [4];
    logic [7:0] pin_raw [4];
    assign pin_raw[0] = seven_pin_i;
    assign pin_raw[1] = eight_pin_i;
    assign pin_raw[2] = nine_pin_i;
    assign pin_raw[3] = ten_pin_i;

    // pins are asynchronous, so no logic reads a raw level
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sync
            pin_sync u_sync (
                .clk_sys (clk_sys),
                .rst     (rst),
                .pin_in  (pin_raw[g]),
                .pin_out (pin_s[g])
            );
        end
    endgenerate

    // ****************************************************************
    // port seven mode decode
    // ****************************************************************
    wire       analog_input_disable_flag = conv_q[`CONV_ANALOG_OFF_BIT];
    wire [7:0] seven_out  = dir_q[0];                               // [RL4]
    wire [7:0] seven_din  = ~dir_q[0] & latch_q[0];                 // [RL4] [RL5]
    wire [7:0] seven_ana  = analog_input_disable_flag ? 8'h00 : (~dir_q[0] & ~latch_q[0]); // [RL5]
    // forced-zero and analog bits both read zero, so only digital inputs pass the pin
    wire [7:0] seven_rd   = (seven_out & latch_q[0]) | (seven_din & pin_s[0]); // [RL3] [RL6] [RL15]

    // drivers off while stopped without the drive gate
    wire       drive_kill = sys_q[`SYS_STOP_BIT] & ~sys_q[`SYS_DRIVE_BIT]; // [RL16]

    // ****************************************************************
    // pin-side next values
    // ****************************************************************
    // a stopped chip with the drive gate shut drives no pin; pull-ups on input bits stay on
    wire [7:0] seven_oe_n_d = ~(seven_out & {8{~drive_kill}});    // [RL4] [RL16]
    wire [7:0] eight_oe_n_d = ~(dir_q[1] & {8{~drive_kill}});     // [RL12] [RL16]
    wire [7:0] nine_oe_n_d  = ~(dir_q[2] & {8{~drive_kill}});     // [RL13] [RL16]
    wire [7:0] ten_oe_n_d   = ~(dir_q[3] & {8{~drive_kill}});     // [RL14] [RL16]
    // pull-ups follow the direction, so a driven bit never carries one
    wire [7:0] seven_pu_d   = seven_pu_q & ~dir_q[0];             // [RL9]
    wire [7:0] ten_pu_d     = ten_pu_q & ~dir_q[3];               // [RL9]
    // only the upper four pins of port seven can wake the chip
    wire [3:0] wake_d       = pin_s[0][7:4] & wake_q[`WAKE_EN_LSB +: 4]; // [RL8]

    // input bits return the pin, output bits the latch
    function automatic gpio_pkg::byte_t port_rd(input gpio_pkg::byte_t dir,
                                                input gpio_pkg::byte_t lat,
                                                input gpio_pkg::byte_t pin);
        port_rd = (dir & lat) | (~dir & pin); // [RL15]
    endfunction

    // ****************************************************************
    // ahb-lite write decode on the registered address, in the data phase
    // ****************************************************************
    wire take = hsel & hready & htrans[1];
    wire [31:0] a = addr_q;
    wire h_s7l = hit(a, `IDX_SEVEN_LATCH);
    wire h_s7d = hit(a, `IDX_SEVEN_DIR);
    wire h_e8l = hit(a, `IDX_EIGHT_LATCH);
    wire h_e8d = hit(a, `IDX_EIGHT_DIR);
    wire h_s7p = hit(a, `IDX_SEVEN_PULLUP);
    wire h_n9l = hit(a, `IDX_NINE_LATCH);
    wire h_n9d = hit(a, `IDX_NINE_DIR);
    wire h_t0l = hit(a, `IDX_TEN_LATCH);
    wire h_t0d = hit(a, `IDX_TEN_DIR);
    wire h_t0p = hit(a, `IDX_TEN_PULLUP);
    wire h_cnv = hit(a, `IDX_CONV_CTRL);
    wire h_wak = hit(a, `IDX_WAKE_CTRL);
    wire h_sys = hit(a, `IDX_SYS_CTRL);
    wire h_e8p = hit(a, `IDX_EIGHT_PIN);
    wire h_n9p = hit(a, `IDX_NINE_PIN);
    wire h_t0q = hit(a, `IDX_TEN_PIN);
    wire [7:0] wb = hwdata[7:0];
    // the phase flag backs the pending write, so a stray pulse cannot write
    wire       we = wr_pend_q & (phase_q == gpio_pkg::ST_DATA);

    // ****************************************************************
    // read decode on the address phase
    // ****************************************************************
    // read data is fetched at the address phase edge so that it stands
    // through the data phase; a read right behind a write to the same
    // register returns the value from before that write
    wire r_s7l = hit(haddr, `IDX_SEVEN_LATCH);
    wire r_s7d = hit(haddr, `IDX_SEVEN_DIR);
    wire r_e8l = hit(haddr, `IDX_EIGHT_LATCH);
    wire r_e8d = hit(haddr, `IDX_EIGHT_DIR);
    wire r_s7p = hit(haddr, `IDX_SEVEN_PULLUP);
    wire r_n9l = hit(haddr, `IDX_NINE_LATCH);
    wire r_n9d = hit(haddr, `IDX_NINE_DIR);
    wire r_t0l = hit(haddr, `IDX_TEN_LATCH);
    wire r_t0d = hit(haddr, `IDX_TEN_DIR);
    wire r_t0p = hit(haddr, `IDX_TEN_PULLUP);
    wire r_cnv = hit(haddr, `IDX_CONV_CTRL);
    wire r_wak = hit(haddr, `IDX_WAKE_CTRL);
    wire r_sys = hit(haddr, `IDX_SYS_CTRL);
    wire r_e8p = hit(haddr, `IDX_EIGHT_PIN);
    wire r_n9p = hit(haddr, `IDX_NINE_PIN);
    wire r_t0q = hit(haddr, `IDX_TEN_PIN);
    wire rd_take = take & ~hwrite;

    // read mux; unmapped addresses read zero
    wire [7:0] rd_byte =
        r_s7l ? seven_rd :
        r_s7d ? dir_q[0] :
        r_e8l ? port_rd(dir_q[1], latch_q[1], pin_s[1]) :
        r_e8d ? dir_q[1] :
        r_s7p ? seven_pu_q :
        r_n9l ? port_rd(dir_q[2], latch_q[2], pin_s[2]) :
        r_n9d ? dir_q[2] :
        r_t0l ? port_rd(dir_q[3], latch_q[3], pin_s[3]) :
        r_t0d ? dir_q[3] :
        r_t0p ? ten_pu_q :
        r_cnv ? conv_q :
        r_wak ? wake_q :
        r_sys ? sys_q :
        r_e8p ? pin_s[1] :
        r_n9p ? pin_s[2] :
        r_t0q ? pin_s[3] : 8'h00;
    // only the low byte carries a register; the rest reads zero
    wire [31:0] rd_word = {24'h000000, rd_byte};

    // ****************************************************************
    // bus phase tracking; zero wait states, response always okay
    // ****************************************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            phase_q   <= gpio_pkg::ST_ADDR;
            wr_pend_q <= 1'b0;
            addr_q    <= 32'h0000_0000;
        end else begin
            phase_q   <= take ? gpio_pkg::ST_DATA : gpio_pkg::ST_ADDR;
            wr_pend_q <= take & hwrite;
            if (take) begin
                addr_q <= haddr;
            end
        end
    end

    // read data registered at the address phase edge, standing for the data phase
    // hreadyout never drops: every register answers without wait states
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hrdata    <= rd_take ? rd_word : 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ****************************************************************
    // register writes
    // ****************************************************************
    // all eight latch bits take the written byte, input bits included
    // so a read-modify-write on a port with inputs copies pin levels into the latch
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                latch_q[i] <= `RST_BYTE;                            // [RL2] [RL12] [RL13] [RL14]
                dir_q[i]   <= `RST_BYTE;                            // [RL1] [RL2] [RL12] [RL13] [RL14]
            end
            seven_pu_q <= `RST_BYTE;
            ten_pu_q   <= `RST_BYTE;
            conv_q     <= `RST_CONV;                                // [RL2]
            wake_q     <= `RST_BYTE;
            sys_q      <= `RST_SYS;
        end else if (we) begin
            if (h_s7l) latch_q[0] <= wb;                            // [RL15]
            if (h_s7d) dir_q[0]   <= wb;                            // [RL1]
            if (h_e8l) latch_q[1] <= wb;
            if (h_e8d) dir_q[1]   <= wb;                            // [RL12]
            if (h_n9l) latch_q[2] <= wb;
            if (h_n9d) dir_q[2]   <= wb;
            if (h_t0l) latch_q[3] <= wb;
            if (h_t0d) dir_q[3]   <= wb;
            if (h_s7p) seven_pu_q <= wb;
            if (h_t0p) ten_pu_q   <= wb;
            if (h_cnv) conv_q     <= wb;
            if (h_wak) wake_q     <= wb;
            if (h_sys) sys_q      <= wb;
        end
    end

    // ****************************************************************
    // registered pin-side outputs
    // ****************************************************************
    // oe_n low drives the pin; pull-ups only on non-output bits
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            seven_pin_o           <= 8'h00;
            seven_pin_oe_n        <= 8'hFF;
            seven_pullup_on       <= 8'h00;
            seven_analog_connect  <= 8'h00;
            analog_channel_select <= 4'h0;
            key_wakeup_level      <= 4'h0;
            eight_pin_o           <= 8'h00;
            eight_pin_oe_n        <= 8'hFF;
            nine_pin_o            <= 8'h00;
            nine_pin_oe_n         <= 8'hFF;
            ten_pin_o             <= 8'h00;
            ten_pin_oe_n          <= 8'hFF;
            ten_pullup_on         <= 8'h00;
        end else begin
            seven_pin_o           <= latch_q[0];
            seven_pin_oe_n        <= seven_oe_n_d;                      // [RL4] [RL16]
            seven_pullup_on       <= seven_pu_d;                        // [RL9]
            seven_analog_connect  <= seven_ana;                         // [RL5]
            analog_channel_select <= conv_q[`CONV_CHAN_LSB +: 4];       // [RL7]
            key_wakeup_level      <= wake_d;                            // [RL8]
            eight_pin_o           <= latch_q[1];
            eight_pin_oe_n        <= eight_oe_n_d;                      // [RL12] [RL16]
            nine_pin_o            <= latch_q[2];
            nine_pin_oe_n         <= nine_oe_n_d;                       // [RL16]
            ten_pin_o             <= latch_q[3];
            ten_pin_oe_n          <= ten_oe_n_d;                        // [RL16]
            ten_pullup_on         <= ten_pu_d;                          // [RL9]
        end
    end

endmodule
`default_nettype wire


// File: gpio_ports_props.sv
// assertion checker for the four-port gpio block
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_props (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic [7:0]  seven_pin_oe_n,
    input wire logic [7:0]  seven_pullup_on,
    input wire logic [7:0]  seven_analog_connect,
    input wire logic [7:0]  eight_pin_o,
    input wire logic [7:0]  eight_pin_oe_n,
    input wire logic [7:0]  ten_pin_oe_n,
    input wire logic [7:0]  ten_pullup_on
);
    // ****
    // properties
    // ****
    wire logic wr;
    // a taken write; pin controls may only move two or three cycles after one
    assign wr = hsel & hready & htrans[1] & hwrite;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_seven_pullup_out: assert property ((seven_pullup_on & ~seven_pin_oe_n) == 8'h00)
        else $error("pull-up on a driven port seven pin");
    a_ten_pullup_out: assert property ((ten_pullup_on & ~ten_pin_oe_n) == 8'h00)
        else $error("pull-up on a driven port ten pin");
    a_analog_undriven: assert property ((seven_analog_connect & ~seven_pin_oe_n) == 8'h00)
        else $error("driven pin joined to the converter");
    a_reset_state: assert property ($fell(rst) |-> seven_pin_oe_n == 8'hFF && eight_pin_oe_n == 8'hFF
        && eight_pin_o == 8'h00 && seven_analog_connect == 8'h00) else $error("state after reset wrong");
    a_dir_by_write: assert property (!$stable(eight_pin_oe_n) |-> $past(wr, 2) || $past(wr, 3))
        else $error("port eight enables moved with no write");
    a_latch_by_write: assert property (!$stable(eight_pin_o) |-> $past(wr, 2) || $past(wr, 3))
        else $error("port eight latch moved with no write");
    a_seven_by_write: assert property (!$stable(seven_pin_oe_n) |-> $past(wr, 2) || $past(wr, 3))
        else $error("port seven enables moved with no write");
    a_rdata_upper: assert property (hrdata[31:8] == 24'h000000)
        else $error("read data above the byte not zero");
endmodule
bind gpio_ports gpio_ports_props u_props (.clk_sys, .rst, .hsel, .htrans, .hwrite, .hready, .hrdata,
    .seven_pin_oe_n, .seven_pullup_on, .seven_analog_connect, .eight_pin_o, .eight_pin_oe_n,
    .ten_pin_oe_n, .ten_pullup_on);
`default_nettype wire

// File: pin_model.sv
// model of the board pins outside one port
`timescale 1ns/1ps
`default_nettype none
module pin_model (
    input  wire logic [7:0] o,
    input  wire logic [7:0] oe_n,
    input  wire logic [7:0] pu,
    input  wire logic [7:0] ext,
    output var  logic [7:0] lvl
);
    // a driven pin shows its driver; an undriven one goes to its pull-up or the outside level
    always_comb lvl = (~oe_n & o) | (oe_n & (pu | ext));
endmodule
`default_nettype wire

// File: test_gpio_ports.sv
// self-checking testbench for the four-port gpio block
`timescale 1ns/1ps
`default_nettype none
`include "gpio_params.svh"
module test_gpio_ports;
    // ****
    // bench
    // ****
    logic        clk_sys, rst, hsel, hwrite, hreadyout, hresp;
    wire  logic  hready;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [7:0]  pi7, po7, oe7, pu7, an7, pi8, po8, oe8, pi9, po9, oe9, pia, poa, oea, pua;
    logic [7:0]  ext7, ext8, ext9, exta;
    logic [3:0]  chan, wake;
    int          fails, n_compared;
    assign hready = hreadyout;
    // the single slave's ready is the bus ready
    gpio_ports dut (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .seven_pin_i(pi7), .seven_pin_o(po7), .seven_pin_oe_n(oe7), .seven_pullup_on(pu7),
        .seven_analog_connect(an7), .analog_channel_select(chan), .key_wakeup_level(wake),
        .eight_pin_i(pi8), .eight_pin_o(po8), .eight_pin_oe_n(oe8), .nine_pin_i(pi9), .nine_pin_o(po9),
        .nine_pin_oe_n(oe9), .ten_pin_i(pia), .ten_pin_o(poa), .ten_pin_oe_n(oea), .ten_pullup_on(pua));
    pin_model m7 (.o(po7), .oe_n(oe7), .pu(pu7), .ext(ext7), .lvl(pi7));
    pin_model m8 (.o(po8), .oe_n(oe8), .pu(8'h00), .ext(ext8), .lvl(pi8));
    pin_model m9 (.o(po9), .oe_n(oe9), .pu(8'h00), .ext(ext9), .lvl(pi9));
    pin_model ma (.o(poa), .oe_n(oea), .pu(pua), .ext(exta), .lvl(pia));
    // free-running system clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic stop_test();
        if (fails == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask
    // waits for ready under a bound; a stuck bus ends the run
    task automatic hold();
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            fails++;
            stop_test();
        end
    endtask
    task automatic bus(input logic [11:0] idx, input logic w, input logic [7:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= {18'h00000, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        hold();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h000000, d};
        hold();
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask
    task automatic wr(input logic [11:0] i, input logic [7:0] d);
        bus(i, 1'b1, d);
    endtask
    task automatic rdc(input string nm, input logic [11:0] i, input logic [7:0] e);
        bus(i, 1'b0, 8'h00);
        chk(nm, {24'h000000, e}, rd);
    endtask
    // four cycles covers write landing, output register and the pin synchroniser
    task automatic settle();
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic t_reset();
        chk("oe", 32'hFFFFFFFF, {oe7, oe8, oe9, oea});
        chk("po", 32'h00000000, {po7, po8, po9, poa});
        wr(`IDX_SEVEN_PULLUP, 8'hFF);
        settle();
        rdc("seven", `IDX_SEVEN_LATCH, 8'h00);
        rdc("conv", `IDX_CONV_CTRL, 8'h10);
        rdc("unmapped", 12'h100, 8'h00);
    endtask
    // low nibble driven from the latch, high nibble from the outside level 3C
    task automatic t_port(input logic [11:0] li, input logic [11:0] di, input logic [11:0] pn, input int p);
        logic [15:0] v;
        wr(di, 8'h0F);
        wr(li, 8'hA5);
        settle();
        v = p == 0 ? {oe8, po8} : p == 1 ? {oe9, po9} : {oea, poa};
        chk("port", 32'h0000F0A5, {16'h0000, v});
        rdc("latch", li, 8'h35);
        rdc("pins", pn, 8'h35);
    endtask
    // outputs and digital inputs set before the converter is enabled, so no analog pin is driven
    task automatic t_seven();
        wr(`IDX_SEVEN_DIR, 8'h03);
        wr(`IDX_SEVEN_LATCH, 8'h0C);
        wr(`IDX_CONV_CTRL, 8'h09);
        settle();
        chk("analog", 32'hF0, {24'h0, an7});
        chk("chan", 32'h9, {28'h0, chan});
        chk("oe7", 32'hFC, {24'h0, oe7});
        chk("po7", 32'h0C, {24'h0, po7});
        chk("pu7", 32'hFC, {24'h0, pu7});
        rdc("seven", `IDX_SEVEN_LATCH, 8'h0C);
        wr(`IDX_CONV_CTRL, 8'h19);
        settle();
        chk("analog", 32'h00, {24'h0, an7});
        rdc("seven", `IDX_SEVEN_LATCH, 8'h0C);
    endtask
    task automatic t_wake();
        wr(`IDX_SEVEN_PULLUP, 8'h00);
        wr(`IDX_SEVEN_LATCH, 8'hFC);
        wr(`IDX_WAKE_CTRL, 8'h50);
        ext7 <= 8'hF0;
        settle();
        chk("wake", 32'h5, {28'h0, wake});
        ext7 <= 8'h0F;
        settle();
        chk("wake", 32'h0, {28'h0, wake});
    endtask
    task automatic t_stop();
        wr(`IDX_EIGHT_DIR, 8'hFF);
        wr(`IDX_TEN_PULLUP, 8'hFF);
        wr(`IDX_SYS_CTRL, 8'h80);
        settle();
        chk("stop", 32'hFFFF, {16'h0, oe7, oe8});
        wr(`IDX_SYS_CTRL, 8'h90);
        settle();
        chk("oe8", 32'h00, {24'h0, oe8});
        chk("pua", 32'hF0, {24'h0, pua});
        rdc("tenpins", `IDX_TEN_PIN, 8'hF5);
    endtask
    // main sequence
    initial begin
        rst = 1'b1;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'b010;
        {ext7, ext8, ext9, exta} = 32'hFF3C3C3C;
        fails = 0;
        n_compared = 0;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_port(`IDX_EIGHT_LATCH, `IDX_EIGHT_DIR, `IDX_EIGHT_PIN, 0);
        t_port(`IDX_NINE_LATCH, `IDX_NINE_DIR, `IDX_NINE_PIN, 1);
        t_port(`IDX_TEN_LATCH, `IDX_TEN_DIR, `IDX_TEN_PIN, 2);
        t_seven();
        t_wake();
        t_stop();
        stop_test();
    end
endmodule
`default_nettype wire
